// ==== inc/sport_pkg.sv ====
// constants and types for the dual serial audio port with its dma engine
// assumes one 25 MHz clock; link clocks and frame syncs are sampled pins
// How it works
// - two independent serial ports, bit clock up to half the system clock
// - every port has primary and secondary data lines per direction
// - transmit and receive sides each own configuration, clocking and data path
// - dma moves words between memory and the port fifos without the core
// - each port runs dsp serial, i2s stereo or tdm multichannel framing
// - bit order per side: least or most significant bit first
// - word length programmable from three to thirty-two bits
// - frame sync style follows mode; mu-law or a-law companding or bypass
// - bit clock generated inside or taken from the peripheral; frame sync too, generated inside only with the inside bit clock
// - receive words compared against keyword under keymask; mismatches dropped
// - eight dma channels serve the serial ports, one per data line and direction
// - a channel pulses done when its transfer completes without chaining further
// - a channel whose count runs out with a nonzero chain address fetches the next descriptor itself and continues
package sport_pkg;
   localparam int NUM_PORTS = 2;
   localparam int NUM_SIDES = 4;
   localparam int NUM_CH = 8;
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 16;
   localparam int LEN_W = 5;
   localparam int DIV_W = 8;
   localparam int MEM_AW = 12;
   localparam int CNT_W = 8;
   localparam logic [4:0] MIN_LEN_M1 = 5'h02;
   localparam logic [4:0] CMP_LEN_M1 = 5'h07;
   localparam int DESC_NEXT_LSB = 20;
   localparam int DESC_BASE_LSB = 8;
   localparam int DESC_CNT_LSB = 0;
   localparam logic [15:0] MU_BIAS = 16'h0084;
   localparam logic [15:0] MU_CLIP = 16'h7F7B;
   localparam logic [7:0] A_XOR = 8'h55;
   typedef enum logic [1:0] {MODE_DSP, MODE_I2S, MODE_TDM} mode_e;
   typedef enum logic [1:0] {CMP_NONE, CMP_MU, CMP_A} comp_e;
   typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_WAIT} dma_state_e;
endpackage

// ==== rtl/sport_top.sv ====
// dual serial audio port: shifters, framing, companding, key filter, fifos, dma
// assumes a single-ported word memory with a ready handshake and one-cycle read data

module sport_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic wen;

   always_comb begin
      in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
      out_valid = wr_q != rd_q;
      out_data = mem[rd_q[AW-1:0]];
      wen = in_valid && in_ready;
      wr_d = wen ? wr_q + 1'b1 : wr_q;
      rd_d = (out_valid && out_ready) ? rd_q + 1'b1 : rd_q;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   always_ff @(posedge clk) begin
      if (wen) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule

module sport_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0][1:0] port_mode,
   input wire logic [1:0][4:0] tdm_slots,
   input wire logic [3:0] side_en,
   input wire logic [7:0] chan_en,
   input wire logic [3:0] lsb_first,
   input wire logic [3:0][4:0] word_len,
   input wire logic [3:0][1:0] compand,
   input wire logic [3:0] int_clk,
   input wire logic [3:0] int_fs,
   input wire logic [3:0][7:0] clk_div,
   input wire logic [1:0] key_en,
   input wire logic [1:0][31:0] keyword,
   input wire logic [1:0][31:0] keymask,
   input wire logic [3:0] sclk_i,
   output logic [3:0] sclk_o,
   output logic [3:0] sclk_oe,
   input wire logic [3:0] fs_i,
   output logic [3:0] fs_o,
   output logic [3:0] fs_oe,
   output logic [3:0] tx_dout,
   input wire logic [3:0] rx_din,
   output logic [1:0] key_hit,
   output logic [7:0] fifo_err,
   input wire logic [7:0] dma_start,
   input wire logic [7:0][11:0] dma_base,
   input wire logic [7:0][7:0] dma_count,
   input wire logic [7:0][11:0] dma_chain,
   output logic [7:0] dma_busy,
   output logic [7:0] dma_done,
   output logic mem_en,
   output logic mem_we,
   output logic [11:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ready,
   input wire logic [31:0] mem_rdata
);
   logic [7:0] f_in_ready, f_out_valid, dma_push, dma_pop, need;
   logic [7:0][31:0] f_out_data;
   logic [3:0] din_m_q, din_s_q;

   function automatic logic [7:0] compress(input logic [15:0] x, input logic alaw);
      logic [15:0] mag;
      logic [2:0] seg;
      logic [3:0] man;
      logic neg;
      neg = x[15];
      seg = 3'h0;
      if (alaw) begin
         mag = neg ? (~x >> 3) : (x >> 3);
         for (int i = 5; i < 12; i++) begin
            if (mag[i]) seg = 3'(i - 4);
         end
         man = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
         compress = {~neg, seg, man} ^ sport_pkg::A_XOR;
      end else begin
         mag = neg ? 16'(~x + 16'h0001) : x;
         mag = (mag > sport_pkg::MU_CLIP) ? sport_pkg::MU_CLIP : mag;
         mag = mag + sport_pkg::MU_BIAS;
         for (int i = 8; i < 15; i++) begin
            if (mag[i]) seg = 3'(i - 7);
         end
         man = 4'(mag >> (4'(seg) + 4'h3));
         compress = ~{neg, seg, man};
      end
   endfunction

   function automatic logic [15:0] expand(input logic [7:0] code, input logic alaw);
      logic [7:0] v;
      logic [15:0] t;
      if (alaw) begin
         v = code ^ sport_pkg::A_XOR;
         t = {8'h00, v[3:0], 4'h8};
         if (v[6:4] != 3'h0) t = (t + 16'h0100) << (v[6:4] - 3'h1);
         expand = v[7] ? t : 16'h0000 - t;
      end else begin
         v = ~code;
         t = ({9'h000, v[3:0], 3'h0} + sport_pkg::MU_BIAS) << v[6:4];
         expand = v[7] ? sport_pkg::MU_BIAS - t : t - sport_pkg::MU_BIAS;
      end
   endfunction

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         din_m_q <= '0;
         din_s_q <= '0;
      end else begin
         din_m_q <= rx_din;
         din_s_q <= din_m_q;
      end
   end

   // side s: port s/2, odd sides receive
   for (genvar s = 0; s < sport_pkg::NUM_SIDES; s++) begin : g_side
      localparam int P = s / 2;
      localparam bit RX = (s % 2) == 1;
      logic sm_q, ss_q, fm_q, fsy_q, cko_q, cko_d, fso_q, fso_d;
      logic sck_q, sck_d, fsg_q, fsg_d, prev_q, fsp_q, fsp_d, act_q, act_d, hit_q, hit_d;
      logic [7:0] div_q, div_d;
      logic [4:0] gw_q, gw_d, gs_q, gs_d, bit_q, bit_d, slot_q, slot_d, len, nsl;
      logic [1:0][31:0] sh_q, sh_d, pdata;
      logic [1:0] dout_q, dout_d, push, pop, err_q, err_d;
      logic sel, rise, fall, fsv, start, isi2s, lastw, load, match, alaw;
      logic [31:0] w;
      logic [15:0] e;

      always_comb begin
         isi2s = port_mode[P] == 2'(sport_pkg::MODE_I2S);
         alaw = compand[s] == 2'(sport_pkg::CMP_A);
         if (compand[s] != 2'(sport_pkg::CMP_NONE)) len = sport_pkg::CMP_LEN_M1;
         else if (word_len[s] < sport_pkg::MIN_LEN_M1) len = sport_pkg::MIN_LEN_M1;
         else len = word_len[s];
         if (port_mode[P] == 2'(sport_pkg::MODE_DSP)) nsl = 5'h00;
         else nsl = isi2s ? 5'h01 : tdm_slots[P];
         cko_d = side_en[s] && int_clk[s];
         fso_d = side_en[s] && int_fs[s];
         div_d = div_q;
         sck_d = sck_q;
         gw_d = gw_q;
         gs_d = gs_q;
         fsg_d = fsg_q;
         lastw = 1'b0;
         // internal bit clock divider and frame generator
         if (cko_d) begin
            if (div_q >= clk_div[s]) begin
               div_d = 8'h00;
               sck_d = ~sck_q;
               if (sck_q) begin
                  lastw = gw_q == len;
                  gw_d = lastw ? 5'h00 : gw_q + 5'h01;
                  if (lastw) gs_d = (gs_q >= nsl) ? 5'h00 : gs_q + 5'h01;
                  // i2s: word select flips during last bit; else one-bit pulse
                  fsg_d = isi2s ? (gs_d[0] ^ (gw_d == len)) : (gw_d == len && gs_d == nsl);
               end
            end else begin
               div_d = div_q + 8'h01;
            end
         end
         sel = int_clk[s] ? sck_q : ss_q;
         rise = side_en[s] && sel && !prev_q;
         fall = side_en[s] && !sel && prev_q;
         fsv = int_fs[s] ? fsg_q : fsy_q;
         start = isi2s ? (fsv != fsp_q) : fsv;
         act_d = act_q;
         bit_d = bit_q;
         slot_d = slot_q;
         sh_d = sh_q;
         fsp_d = fsp_q;
         dout_d = dout_q;
         push = '0;
         pop = '0;
         err_d = '0;
         hit_d = 1'b0;
         pdata = '0;
         load = 1'b0;
         match = 1'b0;
         w = '0;
         e = '0;
         if (rise) begin
            fsp_d = fsv;
            if (act_q) begin
               if (RX) begin
                  for (int k = 0; k < 2; k++) begin
                     w = lsb_first[s] ? (sh_q[k] >> 1) : (sh_q[k] << 1);
                     w[lsb_first[s] ? len : 5'h00] = din_s_q[P * 2 + k];
                     sh_d[k] = w;
                  end
               end
               if (bit_q == len) begin
                  bit_d = 5'h00;
                  if (port_mode[P] == 2'(sport_pkg::MODE_TDM) && slot_q < nsl) begin
                     slot_d = slot_q + 5'h01;
                     load = 1'b1;
                  end else begin
                     act_d = 1'b0;
                  end
                  if (RX) begin
                     for (int k = 0; k < 2; k++) begin
                        match = !key_en[P] || ((sh_d[k] ^ keyword[P]) & ~keymask[P]) == '0;
                        e = expand(sh_d[k][7:0], alaw);
                        pdata[k] = (compand[s] != 2'(sport_pkg::CMP_NONE)) ?
                                   {{16{e[15]}}, e} : sh_d[k];
                        push[k] = chan_en[s * 2 + k] && match;
                        hit_d = hit_d || (key_en[P] && match);
                        err_d[k] = push[k] && !f_in_ready[s * 2 + k];
                     end
                  end
               end else begin
                  bit_d = bit_q + 5'h01;
               end
            end
            if (start) begin
               act_d = 1'b1;
               bit_d = 5'h00;
               slot_d = 5'h00;
               load = 1'b1;
            end
         end
         if (load) begin
            for (int k = 0; k < 2; k++) begin
               sh_d[k] = '0;
               if (!RX && chan_en[s * 2 + k]) begin
                  if (f_out_valid[s * 2 + k]) begin
                     pop[k] = 1'b1;
                     sh_d[k] = (compand[s] != 2'(sport_pkg::CMP_NONE)) ?
                               {24'h000000, compress(f_out_data[s * 2 + k][15:0], alaw)} :
                               f_out_data[s * 2 + k];
                  end else begin
                     err_d[k] = 1'b1;
                  end
               end
            end
         end
         if (fall && act_q && !RX) begin
            for (int k = 0; k < 2; k++) begin
               dout_d[k] = lsb_first[s] ? sh_q[k][0] : sh_q[k][len];
               sh_d[k] = lsb_first[s] ? (sh_q[k] >> 1) : (sh_q[k] << 1);
            end
         end
      end

      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            {sm_q, ss_q, fm_q, fsy_q, cko_q, fso_q} <= '0;
            {sck_q, fsg_q, prev_q, fsp_q, act_q, hit_q} <= '0;
            div_q <= '0;
            {gw_q, gs_q, bit_q, slot_q} <= '0;
            sh_q <= '0;
            dout_q <= '0;
            err_q <= '0;
         end else begin
            sm_q <= sclk_i[s];
            ss_q <= sm_q;
            fm_q <= fs_i[s];
            fsy_q <= fm_q;
            cko_q <= cko_d;
            fso_q <= fso_d;
            sck_q <= sck_d;
            fsg_q <= fsg_d;
            prev_q <= sel;
            fsp_q <= fsp_d;
            act_q <= act_d;
            hit_q <= hit_d;
            div_q <= div_d;
            gw_q <= gw_d;
            gs_q <= gs_d;
            bit_q <= bit_d;
            slot_q <= slot_d;
            sh_q <= sh_d;
            dout_q <= dout_d;
            err_q <= err_d;
         end
      end

      assign sclk_o[s] = sck_q;
      assign sclk_oe[s] = cko_q;
      assign fs_o[s] = fsg_q;
      assign fs_oe[s] = fso_q;
      assign fifo_err[s * 2 +: 2] = err_q;
      if (RX) begin : g_rx
         assign key_hit[P] = hit_q;
      end else begin : g_tx
         assign tx_dout[P * 2 +: 2] = dout_q;
      end

      for (genvar k = 0; k < 2; k++) begin : g_ch
         localparam int C = s * 2 + k;
         sport_fifo #(.WIDTH(sport_pkg::DATA_W), .DEPTH(sport_pkg::FIFO_DEPTH)) u_fifo (
            .clk(clk),
            .reset_n(reset_n),
            .in_valid(RX ? push[k] : dma_push[C]),
            .in_ready(f_in_ready[C]),
            .in_data(RX ? pdata[k] : mem_rdata),
            .out_valid(f_out_valid[C]),
            .out_ready(RX ? dma_pop[C] : pop[k]),
            .out_data(f_out_data[C])
         );
      end
   end

   // dma engine: one memory access in flight, round robin over channels
   sport_pkg::dma_state_e st_q, st_d;
   logic [7:0][11:0] addr_q, addr_d, next_q, next_d;
   logic [7:0][7:0] cnt_q, cnt_d;
   logic [7:0] busy_q, busy_d, done_q, done_d;
   logic [2:0] cur_q, cur_d, rr_q, rr_d, idx;
   logic desc_q, desc_d, men_q, men_d, mwe_q, mwe_d, found;
   logic [11:0] maddr_q, maddr_d;
   logic [31:0] mwd_q, mwd_d;

   always_comb begin
      st_d = st_q;
      addr_d = addr_q;
      next_d = next_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      done_d = '0;
      cur_d = cur_q;
      rr_d = rr_q;
      desc_d = desc_q;
      men_d = men_q;
      mwe_d = mwe_q;
      maddr_d = maddr_q;
      mwd_d = mwd_q;
      dma_push = '0;
      dma_pop = '0;
      found = 1'b0;
      idx = 3'h0;
      for (int c = 0; c < sport_pkg::NUM_CH; c++) begin
         if (dma_start[c] && !busy_q[c]) begin
            busy_d[c] = 1'b1;
            addr_d[c] = dma_base[c];
            cnt_d[c] = dma_count[c];
            next_d[c] = dma_chain[c];
         end
         need[c] = busy_q[c] && ((cnt_q[c] == 8'h00) || (chan_en[c] &&
                   (((c / 2) % 2 == 1) ? f_out_valid[c] : f_in_ready[c])));
      end
      case (st_q)
         sport_pkg::DMA_IDLE: begin
            for (int i = 0; i < sport_pkg::NUM_CH; i++) begin
               idx = 3'(rr_q + 3'(i) + 3'h1);
               if (!found && need[idx]) begin
                  found = 1'b1;
                  cur_d = idx;
               end
            end
            if (found) begin
               rr_d = cur_d;
               men_d = 1'b1;
               desc_d = cnt_q[cur_d] == 8'h00;
               maddr_d = desc_d ? next_q[cur_d] : addr_q[cur_d];
               mwe_d = !desc_d && cur_d[1];
               mwd_d = f_out_data[cur_d];
               dma_pop[cur_d] = mwe_d;
               st_d = sport_pkg::DMA_REQ;
            end
         end
         sport_pkg::DMA_REQ: begin
            if (mem_ready) begin
               men_d = 1'b0;
               st_d = mwe_q ? sport_pkg::DMA_IDLE : sport_pkg::DMA_WAIT;
               if (mwe_q) begin
                  addr_d[cur_q] = addr_q[cur_q] + 12'h001;
                  cnt_d[cur_q] = cnt_q[cur_q] - 8'h01;
               end
            end
         end
         sport_pkg::DMA_WAIT: begin
            if (desc_q) begin
               next_d[cur_q] = mem_rdata[sport_pkg::DESC_NEXT_LSB +: sport_pkg::MEM_AW];
               addr_d[cur_q] = mem_rdata[sport_pkg::DESC_BASE_LSB +: sport_pkg::MEM_AW];
               cnt_d[cur_q] = mem_rdata[sport_pkg::DESC_CNT_LSB +: sport_pkg::CNT_W];
            end else begin
               dma_push[cur_q] = 1'b1;
               addr_d[cur_q] = addr_q[cur_q] + 12'h001;
               cnt_d[cur_q] = cnt_q[cur_q] - 8'h01;
            end
            st_d = sport_pkg::DMA_IDLE;
         end
         default: st_d = sport_pkg::DMA_IDLE;
      endcase
      for (int c = 0; c < sport_pkg::NUM_CH; c++) begin
         if (busy_d[c] && cnt_d[c] == 8'h00 && next_d[c] == 12'h000) begin
            busy_d[c] = 1'b0;
            done_d[c] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= sport_pkg::DMA_IDLE;
         {addr_q, next_q, cnt_q, busy_q, done_q} <= '0;
         {cur_q, rr_q, desc_q, men_q, mwe_q, maddr_q, mwd_q} <= '0;
      end else begin
         st_q <= st_d;
         addr_q <= addr_d;
         next_q <= next_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
         cur_q <= cur_d;
         rr_q <= rr_d;
         desc_q <= desc_d;
         men_q <= men_d;
         mwe_q <= mwe_d;
         maddr_q <= maddr_d;
         mwd_q <= mwd_d;
      end
   end

   assign dma_busy = busy_q;
   assign dma_done = done_q;
   assign mem_en = men_q;
   assign mem_we = mwe_q;
   assign mem_addr = maddr_q;
   assign mem_wdata = mwd_q;
endmodule

// ==== tb/sport_top_assertions.sv ====
// checker for sport_top: dma, memory handshake, link enables, key pulses
// assumes the port names of sport_top; bound below
module sport_top_checker (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] side_en,
   input wire logic [3:0] int_clk,
   input wire logic [3:0] int_fs,
   input wire logic [1:0] key_en,
   input wire logic [3:0] sclk_o,
   input wire logic [3:0] sclk_oe,
   input wire logic [3:0] fs_oe,
   input wire logic [3:0] tx_dout,
   input wire logic [1:0] key_hit,
   input wire logic [7:0] dma_start,
   input wire logic [7:0][7:0] dma_count,
   input wire logic [7:0][11:0] dma_chain,
   input wire logic [7:0] dma_busy,
   input wire logic [7:0] dma_done,
   input wire logic mem_en,
   input wire logic mem_we,
   input wire logic [11:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic mem_ready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_wait;
      mem_en && !mem_ready;
   endsequence
   sequence s_accept;
      mem_en && mem_ready;
   endsequence
   a_mem_hold: assert property (
      s_wait |=> mem_en && $stable({mem_we, mem_addr, mem_wdata}))
      else $error("request changed while waiting");
   a_mem_drop: assert property (s_accept |=> !mem_en)
      else $error("request held after acceptance");
   for (genvar c = 0; c < 8; c++) begin : g_ch
      sequence s_take;
         dma_start[c] && !dma_busy[c];
      endsequence
      a_done_empty: assert property (
         s_take ##0 (dma_count[c] == 8'h00 && dma_chain[c] == 12'h000)
         |=> dma_done[c] && !dma_busy[c])
         else $error("empty transfer not done at once");
      a_busy_take: assert property (
         s_take ##0 (dma_count[c] != 8'h00) |=> dma_busy[c])
         else $error("start not taken");
      a_done_pulse: assert property (dma_done[c] |=> !dma_done[c])
         else $error("done longer than one cycle");
   end
   for (genvar s = 0; s < 4; s++) begin : g_side
      a_sclk_oe: assert property (
         ##1 sclk_oe[s] == $past(side_en[s] && int_clk[s]))
         else $error("clock enable wrong");
      a_fs_oe: assert property (
         ##1 fs_oe[s] == $past(side_en[s] && int_fs[s]))
         else $error("frame sync enable wrong");
      a_sclk_still: assert property (
         (!(side_en[s] && int_clk[s])) [*2] |=> $stable(sclk_o[s]))
         else $error("bit clock moved while off");
   end
   for (genvar p = 0; p < 2; p++) begin : g_port
      a_key_pulse: assert property (
         key_hit[p] |-> $past(key_en[p]) ##1 !key_hit[p])
         else $error("key hit wrong");
      a_tx_hold: assert property (
         (!side_en[2*p]) [*2] |=> $stable(tx_dout[2*p+1:2*p]))
         else $error("tx line moved while off");
   end
endmodule
bind sport_top sport_top_checker sport_top_checker_inst (.*);

// ==== tb/codec_model.sv ====
// codec on port 0: captures the tx line, sends rx words on its own clock
// assumes dsp framing, one word per frame; count and order set by cfg
module codec_model (
   input wire logic dev_sclk,
   input wire logic dev_fs,
   input wire logic dev_dout,
   output logic ext_sclk,
   output logic ext_fs,
   output logic ext_din
);
   timeunit 1ns;
   timeprecision 1ns;
   int nbits = 8;
   int cnt = 0;
   bit lsb = 1'b0;
   logic [31:0] acc = 32'h0;
   logic [31:0] tx_q[$];
   initial begin
      {ext_sclk, ext_fs, ext_din} = 3'h0;
   end
   task automatic cfg(input int n, input bit l);
      nbits = n;
      lsb = l;
      cnt = 0;
      tx_q = {};
   endtask
   // fs at a rising edge: the next rising edges carry the bits
   always @(posedge dev_sclk) begin
      if (cnt > 0) begin
         acc = lsb ? acc | (32'(dev_dout) << (nbits - cnt)) : {acc[30:0], dev_dout};
         cnt--;
         if (cnt == 0)
            tx_q.push_back(acc);
      end
      if (dev_fs) begin
         cnt = nbits;
         acc = 32'h0;
      end
   end
   // clock runs only inside a frame; idle data shows the inverse
   task automatic send(input logic [31:0] w);
      #653 ext_fs = 1'b1;
      #160 ext_sclk = 1'b1;
      for (int i = 0; i < nbits; i++) begin
         #160 ext_sclk = 1'b0;
         ext_fs = 1'b0;
         ext_din = lsb ? w[i] : w[nbits - 1 - i];
         #160 ext_sclk = 1'b1;
      end
      #160 ext_sclk = 1'b0;
      ext_din = ~ext_din;
   endtask
endmodule

// ==== tb/tb_sport_top.sv ====
// bench for sport_top: dma through port 0 to and from the codec model
// assumes the checker binds itself; memory with random stalls lives here
module tb_sport_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0][1:0] port_mode;
   logic [1:0][4:0] tdm_slots;
   logic [3:0] side_en, lsb_first, int_clk, int_fs, sclk_i, fs_i, rx_din;
   logic [3:0] sclk_o, sclk_oe, fs_o, fs_oe, tx_dout;
   logic [7:0] chan_en, fifo_err, dma_start, dma_busy, dma_done;
   logic [3:0][4:0] word_len;
   logic [3:0][1:0] compand;
   logic [3:0][7:0] clk_div;
   logic [1:0] key_en, key_hit;
   logic [1:0][31:0] keyword, keymask;
   logic [7:0][11:0] dma_base, dma_chain;
   logic [7:0][7:0] dma_count;
   logic mem_en, mem_we, mem_ready;
   logic [11:0] mem_addr;
   logic [31:0] mem_wdata, mem_rdata;
   logic [31:0] rnd = 32'h0;
   logic c_sclk, c_fs, c_din;
   logic [31:0] mem [4096];
   logic [31:0] w [20];
   int seed = 36;
   int n_errors = 0;
   int checked = 0;
   int hits = 0;
   int n;
   always #20 clk = ~clk;
   assign sclk_i = {rnd[1:0], c_sclk, rnd[2]};
   assign fs_i = {rnd[4:3], c_fs, rnd[5]};
   // secondary line mirrors the primary so the key hit count stays exact
   assign rx_din = {rnd[7:6], c_din, c_din};
   sport_top sport_top_inst (.*);
   codec_model codec_model_inst (.dev_sclk(sclk_o[0]), .dev_fs(fs_o[0]),
      .dev_dout(tx_dout[0]), .ext_sclk(c_sclk), .ext_fs(c_fs), .ext_din(c_din));
   // read data valid only the cycle after acceptance
   always @(posedge clk) begin
      if (mem_en && mem_ready && mem_we)
         mem[mem_addr] <= mem_wdata;
      mem_rdata <= #2 (mem_en && mem_ready && !mem_we) ? mem[mem_addr] : ~mem_rdata;
      mem_ready <= #2 1'($random(seed));
      rnd <= #2 $random(seed);
      if (key_hit[0])
         hits++;
   end
   task automatic tick(input int k = 1);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checked %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   function automatic bit met(input int c);
      return c < 8 ? dma_busy[c] === 1'b0 : codec_model_inst.tx_q.size() >= c;
   endfunction
   task automatic wait_for(input int c);
      for (int i = 0; i < 8000 && !met(c); i++)
         tick();
      if (!met(c)) begin
         n_errors++;
         results();
      end
   endtask
   function automatic logic [31:0] fit(input logic [31:0] v, input int b);
      return b == 32 ? v : v & ((32'h1 << b) - 32'h1);
   endfunction
   task automatic start(input int c, input logic [11:0] a, input logic [7:0] k);
      dma_base[c] = a;
      dma_count[c] = k;
      dma_start[c] = 1'b1;
      tick();
      dma_start[c] = 1'b0;
   endtask
   initial begin
      {port_mode, tdm_slots, side_en, lsb_first, int_clk, int_fs, word_len, compand} = '0;
      {clk_div, chan_en, key_en, keyword, keymask, dma_base, dma_count, dma_chain} = '0;
      {dma_start, mem_ready, mem_rdata} = '0;
      tick(16);
      reset_n = 1'b1;
      tick();
      check_word({1'b0, dma_busy, dma_done, mem_en, fs_oe, key_hit, fifo_err}, 32'h0);
      start(4, 12'h000, 8'h00);
      check_word(32'({dma_done[4], dma_busy[4]}), 32'h2);
      for (int p = 0; p < 2; p++) begin
         n = p ? 3 + ($unsigned($random(seed)) % 30) : 8;
         chan_en = 8'hFF;
         {int_clk, int_fs} = 8'hDD;
         lsb_first = {rnd[1:0], p[0], p[0]};
         word_len = {rnd[9:0], 5'(n - 1), 5'(n - 1)};
         compand = {rnd[13:10], 4'h0};
         clk_div = {rnd[23:0], 8'h03};
         port_mode[1] = p ? 2'h1 : 2'h2;
         tdm_slots[1] = rnd[4:0];
         side_en = 4'hC;
         for (int i = 0; i < 20; i++) begin
            w[i] = i ? $random(seed) : '1;
            mem[12'h100 + i] = w[i];
            mem[12'h200 + i] = 32'h0;
         end
         mem[12'h180] = w[18];
         mem[12'h181] = w[19];
         mem[12'h040] = 32'h0001_8002;
         dma_chain[0] = 12'h040;
         start(0, 12'h100, 8'h12);
         tick(150);
         check_word(32'(dma_busy[0]), 32'h1);
         codec_model_inst.cfg(n, p[0]);
         side_en[0] = 1'b1;
         wait_for(0);
         wait_for(20);
         side_en[0] = 1'b0;
         for (int i = 0; i < 20; i++)
            check_word(codec_model_inst.tx_q[i], fit(w[i], n));
         key_en[0] = p[0];
         keyword[0] = fit(w[0], n);
         side_en[1] = 1'b1;
         start(2, 12'h200, p ? 8'h03 : 8'h04);
         hits = 0;
         for (int i = 0; i < 4; i++)
            codec_model_inst.send(p ? w[0] ^ 32'(i == 2) : w[i]);
         wait_for(2);
         for (int i = 0; i < 4; i++)
            check_word(mem[12'h200 + i], p ? (i < 3 ? fit(w[0], n) : 0) : fit(w[i], n));
         check_word(hits, p ? 3 : 0);
         side_en = 4'h0;
         tick(20);
      end
      results();
   end
endmodule
